// [rtl/flzc_device.sv]
// Device end of the freeze low power mode controller.
// Assumes the controller drives the request synchronous to clk.
`include "flzc_map.svh"
module flzc_device #(
   parameter int IN_W = 8,
   parameter int BANKS = 2,
   parameter int ENTRY_CYC = `FLZC_ENTRY_CYC,
   parameter int EXIT_CYC = `FLZC_EXIT_CYC,
   parameter int POWERUP_CYC = `FLZC_POWERUP_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link
   flzc_if.dev link,
   // Configuration
   input wire flzc_pkg::flzc_mode_e mode,
   input wire logic in_hold_en,
   // Fabric inputs and I/O
   input wire logic [IN_W-1:0] pad_in,
   input wire logic [IN_W-1:0] core_out,
   // To the fabric
   output logic [IN_W-1:0] core_in,
   output logic [IN_W-1:0] pad_out,
   output logic [BANKS-1:0] bank_active,
   output logic pll_powerdown,
   output logic pll_clk_en,
   output logic state_keep,
   output flzc_pkg::flzc_state_e state
);
   import flzc_pkg::*;
   // ----------------------------------------------------------------
   // Request filter and entry condition
   // ----------------------------------------------------------------
   logic req_filt_n; // Filtered active-low request
   logic enter_cond; // Entry condition
   logic powerup_q; // Still inside the power-up window
   flzc_cnt_t cnt_q; // Phase counter
   flzc_cnt_t pu_cnt_q; // Power-up window counter
   logic frozen_q; // Frozen flag
   logic [IN_W-1:0] pad_hold_q; // Held pad outputs
   logic [IN_W-1:0] in_hold_q; // Held inputs
   // Short pulses on the pin never reach the state machine
   flzc_glitch_filter #(
      .LEN(`FLZC_FILTER_CYC),
      .RST_VAL(1'b1)
   ) u_filt (
      .clk(clk),
      .rst(rst),
      .din(link.freeze_request_n),
      .dout(req_filt_n)
   );
   // Type 1: pin alone type 2: continuous AND
   always_comb begin
      if (mode == FLZC_TYPE1) begin
         enter_cond = !req_filt_n;
      end else begin
         enter_cond = !req_filt_n && link.core_sleep_permit;
      end
   end
   // ----------------------------------------------------------------
   // Power-up window
   // ----------------------------------------------------------------
   // Marks the first stretch after reset; nothing reads it, so a pending
   // request gets the normal entry settle, not a longer power-up allowance
   always_ff @(posedge clk) begin
      if (rst) begin
         pu_cnt_q <= '0;
         powerup_q <= 1'b1;
      end else if (powerup_q) begin
         pu_cnt_q <= pu_cnt_q + 1'b1;
         if (pu_cnt_q == flzc_cnt_t'(POWERUP_CYC - 1)) begin
            powerup_q <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------
   // Entry takes a fixed settle of half the allowed time, well inside
   // both the 1 us and the 5 us bound; exit likewise
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= FLZC_RUN;
         cnt_q <= '0;
      end else begin
         case (state)
            // Normal operation
            FLZC_RUN: begin
               cnt_q <= '0;
               if (enter_cond) begin
                  state <= FLZC_ENTER;
               end
            end
            // Entry in progress; a dropped permit aborts
            FLZC_ENTER: begin
               if (!enter_cond) begin
                  state <= FLZC_RUN;
                  cnt_q <= '0;
               end else if (cnt_q == flzc_cnt_t'(ENTRY_CYC / 2 - 1)) begin
                  state <= FLZC_FROZEN;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            // Frozen; only the pin releases it
            FLZC_FROZEN: begin
               cnt_q <= '0;
               if (req_filt_n) begin
                  state <= FLZC_LEAVE;
               end
            end
            // Exit settle
            FLZC_LEAVE: begin
               if (cnt_q == flzc_cnt_t'(EXIT_CYC / 2 - 1)) begin
                  state <= FLZC_RUN;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            default: begin
               state <= FLZC_RUN;
               cnt_q <= '0;
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Frozen flag drives retention directly, and PLL and I/O one cycle later
   always_ff @(posedge clk) begin
      if (rst) begin
         frozen_q <= 1'b0;
      end else begin
         frozen_q <= (state == FLZC_ENTER && enter_cond
            && cnt_q == flzc_cnt_t'(ENTRY_CYC / 2 - 1)) || state == FLZC_FROZEN;
      end
   end
   // PLL power and clocks follow the freeze
   always_ff @(posedge clk) begin
      if (rst) begin
         pll_powerdown <= 1'b0;
         pll_clk_en <= 1'b1;
      end else begin
         pll_powerdown <= frozen_q;
         pll_clk_en <= !frozen_q;
      end
   end
   // Banks drop one per cycle, low bank first, so order is staged
   // rather than simultaneous
   always_ff @(posedge clk) begin
      if (rst) begin
         bank_active <= '1;
      end else if (frozen_q) begin
         bank_active <= {bank_active[BANKS-2:0], 1'b0};
      end else begin
         bank_active <= '1;
      end
   end
   // Inputs forced high unless hold in use pads held
   always_ff @(posedge clk) begin
      if (rst) begin
         core_in <= '0;
         in_hold_q <= '0;
      end else if (frozen_q) begin
         core_in <= in_hold_en ? in_hold_q : '1;
      end else begin
         core_in <= pad_in;
         in_hold_q <= pad_in;
      end
   end
   // Pad outputs latched at freeze; user logic must latch async paths
   always_ff @(posedge clk) begin
      if (rst) begin
         pad_out <= '0;
         pad_hold_q <= '0;
      end else if (frozen_q) begin
         pad_out <= pad_hold_q;
      end else begin
         pad_out <= core_out;
         pad_hold_q <= core_out;
      end
   end
   // Retention: state is kept, nothing is cleared
   assign state_keep = frozen_q;
   assign link.frozen = frozen_q;
   // Power-up window drives nothing; kept only as an unused signal
   logic unused_pu;
   assign unused_pu = powerup_q;
endmodule : flzc_device

// [common/flzc_map.svh]
// Constants for the freeze low power mode controller.
// Assumes a 125 MHz fabric clock; included by package and modules.
`ifndef FLZC_MAP_SVH
`define FLZC_MAP_SVH
// ----------------------------------------------------------------
// Timing figures in ns and derived cycle counts at 8 ns per clock
// ----------------------------------------------------------------
`define FLZC_CLK_PERIOD_NS 8
`define FLZC_ENTRY_MAX_NS 1000
`define FLZC_EXIT_MAX_NS 1000
`define FLZC_POWERUP_MAX_NS 5000
// Longest times round down
`define FLZC_ENTRY_CYC (`FLZC_ENTRY_MAX_NS / `FLZC_CLK_PERIOD_NS)
`define FLZC_EXIT_CYC (`FLZC_EXIT_MAX_NS / `FLZC_CLK_PERIOD_NS)
`define FLZC_POWERUP_CYC (`FLZC_POWERUP_MAX_NS / `FLZC_CLK_PERIOD_NS)
// Glitch filter length in clocks
`define FLZC_FILTER_CYC 4
// Counter width
`define FLZC_CNT_W 12
`endif

// [common/flzc_pkg.sv]
// Types shared by both ends of the freeze controller.
// Assumes flzc_map.svh on the include path.
`include "flzc_map.svh"
package flzc_pkg;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // Freeze type selection
   typedef enum logic {FLZC_TYPE1, FLZC_TYPE2} flzc_mode_e;
   // Device power state
   typedef enum logic [1:0] {FLZC_RUN, FLZC_ENTER, FLZC_FROZEN, FLZC_LEAVE} flzc_state_e;
   // Cycle counter
   typedef logic [`FLZC_CNT_W-1:0] flzc_cnt_t;
endpackage : flzc_pkg

// [common/flzc_if.sv]
// Link between the device end and the controlling party.
// Assumes both ends share clk.
interface flzc_if (
   input wire logic clk
);
   // Active-low freeze request from the controller
   logic freeze_request_n;
   // Active-high sleep permit from core logic (type 2)
   logic core_sleep_permit;
   // Device reports frozen state
   logic frozen;
   // Controller side
   modport ctrl (input clk, output freeze_request_n, output core_sleep_permit,
      input frozen);
   // Device side
   modport dev (input clk, input freeze_request_n, input core_sleep_permit,
      output frozen);
endinterface : flzc_if

// [rtl/flzc_glitch_filter.sv]
// Glitch filter: output follows input only once stable for LEN clocks.
// Assumes input already synchronous to clk.
module flzc_glitch_filter #(
   parameter int LEN = 4,
   parameter logic RST_VAL = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic din,
   output logic dout
);
   // ----------------------------------------------------------------
   // Stability counter
   // ----------------------------------------------------------------
   logic [7:0] cnt_q; // Cycles input differs from output
   // Count while input differs; short pulses reset the count
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 8'h00;
         dout <= RST_VAL;
      end else if (din == dout) begin
         cnt_q <= 8'h00;
      end else if (cnt_q == 8'(LEN - 1)) begin
         cnt_q <= 8'h00;
         dout <= din;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule : flzc_glitch_filter

// [rtl/flzc_ctrl.sv]
// Controlling party: drives request and permit from user commands.
// Assumes user logic says when data is safe.
module flzc_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link
   flzc_if.ctrl link,
   // User side
   input wire logic user_freeze,
   input wire logic user_data_safe,
   output logic frozen_seen
);
   import flzc_pkg::*;
   // ----------------------------------------------------------------
   // Request and permit
   // ----------------------------------------------------------------
   // The request pin follows the user command alone, so type 1 stays pin-driven.
   // The permit follows user_data_safe each cycle, registered, with no
   // hold through entry. Keeping the two apart lets core
   // logic veto a type 2 entry without touching the pin.
   always_ff @(posedge clk) begin
      if (rst) begin
         link.freeze_request_n <= 1'b1;
         link.core_sleep_permit <= 1'b0;
         frozen_seen <= 1'b0;
      end else begin
         link.freeze_request_n <= !user_freeze;
         link.core_sleep_permit <= user_data_safe;
         frozen_seen <= link.frozen;
      end
   end
endmodule : flzc_ctrl

// [tb/flzc_props.sv]
// Checker for the freeze link between controller and device end.
// Assumes one clock and a synchronous active-high reset.
module flzc_props #(
   parameter int ENTRY_CYC = 16,
   parameter int EXIT_CYC = 16
) (
   // Clock, reset and mode
   input wire logic clk,
   input wire logic rst,
   input wire flzc_pkg::flzc_mode_e mode,
   // Link
   input wire logic freeze_request_n,
   input wire logic core_sleep_permit,
   input wire logic frozen
);
   import flzc_pkg::*;
   // Entry condition for the selected type
   logic cond;
   // Cycles the condition or the release has held
   int cond_cnt_q;
   int rel_cnt_q;
   assign cond = !freeze_request_n && (mode == FLZC_TYPE1 || core_sleep_permit);
   // ----------------------------------------------------------------
   // Hold counters
   // ----------------------------------------------------------------
   // Saturate so a long freeze never wraps back to zero
   always_ff @(posedge clk) begin
      if (rst || !cond) begin
         cond_cnt_q <= 0;
      end else if (cond_cnt_q < 4095) begin
         cond_cnt_q <= cond_cnt_q + 1;
      end
   end
   // Release counter for exit timing
   always_ff @(posedge clk) begin
      if (rst || !freeze_request_n) begin
         rel_cnt_q <= 0;
      end else if (rel_cnt_q < 4095) begin
         rel_cnt_q <= rel_cnt_q + 1;
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Type 2 permit withheld while still running
   sequence permit_off_s;
      (mode == FLZC_TYPE2 && !core_sleep_permit && !frozen) ##1 !core_sleep_permit [*2];
   endsequence
   chk_entry_bound: assert property (cond_cnt_q >= ENTRY_CYC |-> frozen)
      else $error("frozen late after entry condition");
   chk_exit_bound: assert property (rel_cnt_q >= EXIT_CYC |-> !frozen)
      else $error("frozen late to clear after release");
   chk_entry_filter: assert property ($rose(frozen) |-> cond_cnt_q >= 4)
      else $error("entry without a filtered request");
   chk_exit_filter: assert property ($fell(frozen) |-> rel_cnt_q >= 4)
      else $error("exit without a filtered release");
   chk_permit_gate: assert property (permit_off_s |-> !frozen)
      else $error("type 2 froze without permit");
   chk_hold_frozen: assert property (frozen && !freeze_request_n |=> frozen)
      else $error("left freeze while request held");
   chk_stay_running: assert property ((!frozen && freeze_request_n) [*6] |=> !frozen)
      else $error("froze with request released");
   chk_reset_clear: assert property (disable iff (1'b0) rst |=> !frozen)
      else $error("frozen set after reset");
endmodule : flzc_props

// [tb/freeze_low_power_mode_ctrl_tb_top.sv]
// Testbench: controller and device end joined by the link, user side driven.
// Assumes design files and flzc_map.svh compiled first.
module freeze_low_power_mode_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import flzc_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and observed outputs
   // ----------------------------------------------------------------
   localparam int ENT = 16; // Shortened 1 us bounds keep the run brief
   localparam int EXT = 16;
   logic clk = 1'b0;
   logic rst = 1'b1;
   flzc_mode_e mode = FLZC_TYPE1;
   logic in_hold_en = 1'b0;
   logic [7:0] pad_in = 8'h3C;
   logic [7:0] core_out = 8'hA5;
   logic user_freeze = 1'b0;
   logic user_data_safe = 1'b0;
   logic [7:0] core_in;
   logic [7:0] pad_out;
   logic [1:0] bank_active;
   logic pll_powerdown;
   logic pll_clk_en;
   logic state_keep; // Retention flag from the device end
   logic frozen_seen; // Controller's registered copy of frozen
   logic left_run; // Set if the state machine ever leaves RUN
   flzc_state_e state;
   int fails = 0;
   int check_count = 0;
   always #4 clk = ~clk;
   flzc_if link_if (.clk(clk));
   flzc_device #(.IN_W(8), .BANKS(2), .ENTRY_CYC(ENT), .EXIT_CYC(EXT), .POWERUP_CYC(40))
   flzc_device_inst (.clk(clk), .rst(rst), .link(link_if), .mode(mode), .in_hold_en(in_hold_en),
      .pad_in(pad_in), .core_out(core_out), .core_in(core_in), .pad_out(pad_out),
      .bank_active(bank_active), .pll_powerdown(pll_powerdown), .pll_clk_en(pll_clk_en),
      .state_keep(state_keep), .state(state));
   flzc_ctrl flzc_ctrl_inst (.clk(clk), .rst(rst), .link(link_if), .user_freeze(user_freeze),
      .user_data_safe(user_data_safe), .frozen_seen(frozen_seen));
   flzc_props #(.ENTRY_CYC(ENT), .EXIT_CYC(EXT)) flzc_props_inst (.clk(clk), .rst(rst),
      .mode(mode), .freeze_request_n(link_if.freeze_request_n),
      .core_sleep_permit(link_if.core_sleep_permit), .frozen(link_if.frozen));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Verdict, single exit point
   task automatic results();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   // Four-state compare so an unknown never matches
   task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check_vec
   // User commands change just after the edge
   task automatic set_user(input logic frz, input logic safe);
      @(posedge clk);
      user_freeze <= frz;
      user_data_safe <= safe;
   endtask : set_user
   // Wait for the entry or release condition on the wire, then time the answer
   task automatic freeze_to(input logic lvl, input int lim);
      int c;
      logic go;
      c = 0;
      go = 1'b0;
      while (!go) begin
         @(negedge clk);
         c++;
         go = lvl ? (link_if.freeze_request_n === 1'b0 && (mode == FLZC_TYPE1
            || link_if.core_sleep_permit === 1'b1)) : (link_if.freeze_request_n === 1'b1);
         if (c > 400) begin
            fails++;
            $display("[FAIL] %0t wait timed out", $time);
            results();
         end
      end
      c = 0;
      while (link_if.frozen !== lvl && c <= 400) begin
         @(negedge clk);
         c++;
      end
      check_count++;
      if (c > lim) begin
         fails++;
         $display("[FAIL] %0t frozen took %0d cycles", $time, c);
      end
   endtask : freeze_to
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check_vec({pll_clk_en, pll_powerdown, link_if.frozen, 3'h0, bank_active}, 8'h83);
      // Type 1 entry freezes clocks, inputs and banks
      set_user(1'b1, 1'b1);
      freeze_to(1'b1, ENT);
      @(negedge clk);
      check_vec({4'h0, state_keep, frozen_seen, pll_powerdown, pll_clk_en}, 8'h0E);
      check_vec(core_in, 8'hFF);
      @(posedge clk);
      core_out <= 8'h5A; // Registered source, no async in-to-out path
      repeat (3) @(negedge clk);
      check_vec({4'h0, state, bank_active}, 8'h08);
      check_vec(pad_out, 8'hA5);
      set_user(1'b0, 1'b1);
      freeze_to(1'b0, EXT);
      repeat (2) @(negedge clk);
      check_vec({4'h0, state_keep, frozen_seen, pll_powerdown, pll_clk_en}, 8'h01);
      // Three-cycle request pulse is filtered; exit settle must end first
      repeat (8) @(posedge clk);
      set_user(1'b1, 1'b1);
      repeat (2) @(posedge clk);
      set_user(1'b0, 1'b1);
      left_run = 1'b0;
      repeat (30) begin
         @(negedge clk);
         left_run = left_run | (state != FLZC_RUN);
      end
      check_vec({7'h00, left_run}, 8'h00);
      check_vec({7'h00, link_if.frozen}, 8'h00);
      // Type 2 needs the permit as well
      @(posedge clk);
      mode <= FLZC_TYPE2;
      set_user(1'b1, 1'b0);
      repeat (30) @(negedge clk);
      check_vec({7'h00, link_if.frozen}, 8'h00);
      set_user(1'b1, 1'b1);
      freeze_to(1'b1, ENT);
      // Permit dropped while frozen does not release; the pin alone does
      set_user(1'b1, 1'b0);
      repeat (20) @(negedge clk);
      check_vec({7'h00, link_if.frozen}, 8'h01);
      set_user(1'b0, 1'b0);
      freeze_to(1'b0, EXT);
      // Permit dropped mid-entry aborts the entry
      set_user(1'b1, 1'b1);
      repeat (6) @(negedge clk);
      set_user(1'b1, 1'b0);
      repeat (30) @(negedge clk);
      check_vec({7'h00, link_if.frozen}, 8'h00);
      // Type 1 with input hold keeps the last input; permit low is ignored
      set_user(1'b0, 1'b0);
      repeat (10) @(negedge clk);
      @(posedge clk);
      mode <= FLZC_TYPE1;
      in_hold_en <= 1'b1;
      set_user(1'b1, 1'b0);
      freeze_to(1'b1, ENT);
      @(negedge clk);
      check_vec(core_in, 8'h3C);
      // Second reset with the request already asserted
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      freeze_to(1'b1, 40);
      results();
   end
endmodule : freeze_low_power_mode_ctrl_tb_top
